// File: core/axi_master_dma.sv
`default_nettype none
module axi_master_dma
    import dma_axi_pkg::*;
#(
    parameter int AXI_BUS_WIDTH = AXI_WIDTH_DEFAULT,
    parameter int DOUBLE_BUFFERING = DOUBLE_BUF_DEFAULT,
    parameter int inferred_ram_option = INFER_RAM_DEFAULT,
    parameter int DMA_BASE_ADR = DMA_BASE_DEFAULT
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cpu_mem_sel,
    input wire logic cpu_mem_we,
    input wire logic [MEM_AW-1:0] cpu_mem_addr,
    input wire logic [MEM_DW-1:0] cpu_mem_wdata,
    output logic [MEM_DW-1:0] cpu_mem_rdata,
    output logic [NUM_BUF-1:0] irq_vector,
    output logic [31:0] m_axi_awaddr,
    output logic [7:0] m_axi_awlen,
    output logic [1:0] m_axi_awburst,
    output logic m_axi_awvalid,
    input wire logic m_axi_awready,
    output logic [AXI_BUS_WIDTH-1:0] m_axi_wdata,
    output logic m_axi_wlast,
    output logic m_axi_wvalid,
    input wire logic m_axi_wready,
    input wire logic [1:0] m_axi_bresp,
    input wire logic m_axi_bvalid,
    output logic m_axi_bready,
    output logic [31:0] m_axi_araddr,
    output logic [7:0] m_axi_arlen,
    output logic [1:0] m_axi_arburst,
    output logic m_axi_arvalid,
    input wire logic m_axi_arready,
    input wire logic [AXI_BUS_WIDTH-1:0] m_axi_rdata,
    input wire logic [1:0] m_axi_rresp,
    input wire logic m_axi_rlast,
    input wire logic m_axi_rvalid,
    output logic m_axi_rready
);
    // only 8, 16 or 32 accepted; 8 only when inferred_ram_option is 0
    if (!(AXI_BUS_WIDTH == 8 || AXI_BUS_WIDTH == 16 || AXI_BUS_WIDTH == 32)
        || (inferred_ram_option != 0 && AXI_BUS_WIDTH == 8)) begin : g_bad
        $error("AXI data width setting not supported");
    end

    // Memory words per beat: 32-bit beats take two words, low first
    localparam int WPB = (AXI_BUS_WIDTH == 32) ? 2 : 1;
    localparam logic [1:0] WPB_LAST = 2'(WPB - 1);

    // Control word offset of a buffer
    function automatic logic [9:0] ctl_off(input logic [1:0] b);
        case (b)
            2'd0: ctl_off = OFF_WCTRL_A;
            2'd1: ctl_off = OFF_WCTRL_B;
            2'd2: ctl_off = OFF_RCTRL_A;
            default: ctl_off = OFF_RCTRL_B;
        endcase
    endfunction

    // Low address word offset of a buffer
    function automatic logic [9:0] adr_off(input logic [1:0] b);
        case (b)
            2'd0: adr_off = OFF_WADDR_LO_A;
            2'd1: adr_off = OFF_WADDR_LO_B;
            2'd2: adr_off = OFF_RADDR_LO_A;
            default: adr_off = OFF_RADDR_LO_B;
        endcase
    endfunction

    // Payload start of a buffer
    function automatic logic [9:0] buf_off(input logic [1:0] b);
        case (b)
            2'd0: buf_off = OFF_WBUF_A;
            2'd1: buf_off = OFF_WBUF_B;
            2'd2: buf_off = OFF_RBUF_A;
            default: buf_off = OFF_RBUF_B;
        endcase
    endfunction

    dma_state_t state_q;
    logic [1:0] cur_q;
    logic [MEM_DW-1:0] ctl_q;
    logic [31:0] addr_q;
    logic [9:0] ptr_q;
    logic [8:0] beats_q;
    logic [1:0] sub_q;
    logic [31:0] beat_q;
    logic [1:0] resp_q;
    logic [NUM_BUF-1:0] busy_q;
    logic [NUM_BUF-1:0] seen_q;
    logic [NUM_BUF-1:0] irq_q;

    logic e_we;
    logic [MEM_AW-1:0] e_addr;
    logic [MEM_DW-1:0] e_wdata;
    logic [MEM_DW-1:0] e_rdata;
    logic [MEM_DW-1:0] cpu_rd;
    logic [MEM_AW-1:0] cpu_local;
    logic cpu_wr;

    // control words, addresses and payload buffers live in shared memory
    dma_word_ram u_ram (
        .clk(clk),
        .a_we(cpu_wr),
        .a_addr(cpu_local),
        .a_wdata(cpu_mem_wdata),
        .a_rdata(cpu_rd),
        .b_we(e_we),
        .b_addr(e_addr),
        .b_wdata(e_wdata),
        .b_rdata(e_rdata)
    );

    // Processor side is offset by the base address
    assign cpu_local = MEM_AW'(cpu_mem_addr - MEM_AW'(DMA_BASE_ADR));
    assign cpu_wr = cpu_mem_sel & cpu_mem_we;
    assign cpu_mem_rdata = cpu_rd;

    // Active buffers depend on the double-buffer option
    // b buffers only when doubled
    function automatic logic buf_enabled(input logic [1:0] b);
        buf_enabled = (b[0] == 1'b0) || (DOUBLE_BUFFERING != 0);
    endfunction

    // Snoop processor writes to control words for launch and clear.
    // Done is hardware-set; a processor write landing in the same cycle
    // is rewritten by the engine, so the set is never lost.
    logic [NUM_BUF-1:0] launch_w;
    logic [NUM_BUF-1:0] clear_w;
    for (genvar g = 0; g < NUM_BUF; g++) begin : g_snoop
        assign launch_w[g] = buf_enabled(2'(g)) && cpu_wr
            && cpu_local == ctl_off(2'(g))
            && cpu_mem_wdata[CTL_VALID_BIT];
        assign clear_w[g] = cpu_wr && cpu_local == ctl_off(2'(g))
            && !cpu_mem_wdata[CTL_DONE_BIT];
    end

    // Pending launches, taken by the engine in fixed order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_q <= '0;
        end else begin
            for (int i = 0; i < NUM_BUF; i++) begin
                if (launch_w[i]) begin
                    seen_q[i] <= 1'b1;
                end else if (state_q == ST_IDLE && busy_q[i]) begin
                    seen_q[i] <= 1'b0;
                end
            end
        end
    end

    // Pick the lowest pending buffer
    logic [NUM_BUF-1:0] pick_w;
    logic [1:0] pick_idx;
    always_comb begin
        pick_w = '0;
        pick_idx = 2'd0;
        for (int i = NUM_BUF - 1; i >= 0; i--) begin
            if (seen_q[i]) begin
                pick_w = '0;
                pick_w[i] = 1'b1;
                pick_idx = 2'(i);
            end
        end
    end
    assign busy_q = pick_w;

    // Engine memory port steering
    always_comb begin
        e_we = 1'b0;
        e_addr = ctl_off(cur_q);
        e_wdata = '0;
        case (state_q)
            // Registered read: each word is addressed one state early
            ST_RD_CTL: e_addr = ctl_off(cur_q);
            ST_RD_ALO: e_addr = adr_off(cur_q);
            ST_RD_AHI: e_addr = 10'(adr_off(cur_q) + 10'h001);
            ST_FETCH, ST_FETCH_W, ST_WDATA, ST_RDATA, ST_STORE: e_addr = ptr_q;
            default: e_addr = ctl_off(cur_q);
        endcase
        if (state_q == ST_STORE) begin
            e_we = 1'b1;
            e_wdata = beat_q[MEM_DW-1:0];
        end
        if (state_q == ST_DONE) begin
            e_we = 1'b1;
            e_wdata = ctl_q;
            e_wdata[CTL_VALID_BIT] = 1'b0;
            e_wdata[CTL_RESP_MSB:CTL_RESP_LSB] = resp_q;
            e_wdata[CTL_DONE_BIT] = 1'b1;
            e_wdata[15:14] = 2'h0;
        end
    end

    // Main transfer sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cur_q <= 2'd0;
            ctl_q <= '0;
            addr_q <= '0;
            ptr_q <= '0;
            beats_q <= '0;
            sub_q <= '0;
            beat_q <= '0;
            resp_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (|seen_q) begin
                        cur_q <= pick_idx;
                        state_q <= ST_RD_CTL;
                    end
                end
                ST_RD_CTL: state_q <= ST_RD_ALO;
                ST_RD_ALO: begin
                    ctl_q <= e_rdata;
                    state_q <= ST_RD_AHI;
                end
                ST_RD_AHI: begin
                    addr_q[15:0] <= e_rdata;
                    state_q <= ST_ADDR;
                end
                ST_ADDR: begin
                    if (addr_q[31:16] == 16'h0000 && sub_q == 2'd0) begin
                        addr_q[31:16] <= e_rdata;
                        sub_q <= 2'd1;
                        beats_q <= 9'({1'b0, ctl_q[CTL_LEN_MSB:CTL_LEN_LSB]});
                        ptr_q <= buf_off(cur_q);
                    end else if ((cur_q[1] ? m_axi_arready
                                 : m_axi_awready)) begin
                        sub_q <= 2'd0;
                        state_q <= cur_q[1] ? ST_RDATA : ST_FETCH;
                    end
                end
                ST_FETCH: state_q <= ST_FETCH_W;
                ST_FETCH_W: begin
                    if (sub_q == 2'd0) begin
                        beat_q[15:0] <= e_rdata;
                    end else begin
                        beat_q[31:16] <= e_rdata;
                    end
                    ptr_q <= 10'(ptr_q + 10'h001);
                    if (sub_q == WPB_LAST) begin
                        sub_q <= 2'd0;
                        state_q <= ST_WDATA;
                    end else begin
                        sub_q <= 2'(sub_q + 2'd1);
                        state_q <= ST_FETCH;
                    end
                end
                ST_WDATA: begin
                    if (m_axi_wready) begin
                        beats_q <= 9'(beats_q - 9'd1);
                        state_q <= (beats_q == 9'd0) ? ST_BRESP : ST_FETCH;
                    end
                end
                ST_BRESP: begin
                    if (m_axi_bvalid) begin
                        resp_q <= m_axi_bresp;
                        state_q <= ST_DONE;
                    end
                end
                ST_RDATA: begin
                    if (m_axi_rvalid) begin
                        beat_q <= 32'(m_axi_rdata);
                        resp_q <= m_axi_rresp;
                        sub_q <= 2'd0;
                        state_q <= ST_STORE;
                        if (m_axi_rlast) begin
                            beats_q <= 9'd0;
                        end
                    end
                end
                ST_STORE: begin
                    ptr_q <= 10'(ptr_q + 10'h001);
                    beat_q <= {16'h0000, beat_q[31:16]};
                    if (sub_q == WPB_LAST) begin
                        sub_q <= 2'd0;
                        state_q <= (beats_q == 9'd0) ? ST_DONE : ST_RDATA;
                        beats_q <= 9'(beats_q - 9'd1);
                    end else begin
                        sub_q <= 2'(sub_q + 2'd1);
                    end
                end
                ST_DONE: begin
                    addr_q <= '0;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Interrupt per buffer, set by done, cleared by software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= '0;
        end else begin
            for (int i = 0; i < NUM_BUF; i++) begin
                if (state_q == ST_DONE && cur_q == 2'(i)) begin
                    irq_q[i] <= 1'b1;
                end else if (clear_w[i]) begin
                    irq_q[i] <= 1'b0;
                end
            end
        end
    end
    assign irq_vector = irq_q;

    // AXI request channels, driven from held registers
    // burst type from bits 9..8
    assign m_axi_awaddr = addr_q;
    assign m_axi_araddr = addr_q;
    assign m_axi_awlen = ctl_q[CTL_LEN_MSB:CTL_LEN_LSB];
    assign m_axi_arlen = ctl_q[CTL_LEN_MSB:CTL_LEN_LSB];
    assign m_axi_awburst = ctl_q[CTL_TYPE_MSB:CTL_TYPE_LSB];
    assign m_axi_arburst = ctl_q[CTL_TYPE_MSB:CTL_TYPE_LSB];
    assign m_axi_awvalid = state_q == ST_ADDR && sub_q == 2'd1 && !cur_q[1];
    assign m_axi_arvalid = state_q == ST_ADDR && sub_q == 2'd1 && cur_q[1];
    assign m_axi_wdata = AXI_BUS_WIDTH'(beat_q);
    assign m_axi_wvalid = state_q == ST_WDATA;
    assign m_axi_wlast = state_q == ST_WDATA && beats_q == 9'd0;
    assign m_axi_bready = state_q == ST_BRESP;
    assign m_axi_rready = state_q == ST_RDATA;
endmodule
`default_nettype wire

// File: core/dma_axi_pkg.sv
`default_nettype none
package dma_axi_pkg;
    // Shared DMA memory geometry, 16-bit words
    localparam int MEM_DW = 16;
    localparam int MEM_AW = 10;
    localparam int MEM_DEPTH = 1024;
    // Control and address word offsets
    localparam logic [9:0] OFF_WCTRL_A = 10'h000;
    localparam logic [9:0] OFF_WCTRL_B = 10'h001;
    localparam logic [9:0] OFF_RCTRL_A = 10'h002;
    localparam logic [9:0] OFF_RCTRL_B = 10'h003;
    localparam logic [9:0] OFF_WADDR_LO_A = 10'h004;
    localparam logic [9:0] OFF_WADDR_HI_A = 10'h005;
    localparam logic [9:0] OFF_RADDR_LO_A = 10'h006;
    localparam logic [9:0] OFF_RADDR_HI_A = 10'h007;
    localparam logic [9:0] OFF_WADDR_LO_B = 10'h008;
    localparam logic [9:0] OFF_WADDR_HI_B = 10'h009;
    localparam logic [9:0] OFF_RADDR_LO_B = 10'h00A;
    localparam logic [9:0] OFF_RADDR_HI_B = 10'h00B;
    // Payload buffer starts and sizes
    localparam logic [9:0] OFF_WBUF_A = 10'h00C;
    localparam logic [9:0] OFF_WBUF_B = 10'h10A;
    localparam logic [9:0] OFF_RBUF_A = 10'h206;
    localparam logic [9:0] OFF_RBUF_B = 10'h304;
    localparam int BUF_WORDS_SINGLE = 506;
    localparam int BUF_WORDS_DOUBLE = 252;
    // Control word fields
    localparam int CTL_LEN_LSB = 0;
    localparam int CTL_LEN_MSB = 7;
    localparam int CTL_TYPE_LSB = 8;
    localparam int CTL_TYPE_MSB = 9;
    localparam int CTL_VALID_BIT = 10;
    localparam int CTL_RESP_LSB = 11;
    localparam int CTL_RESP_MSB = 12;
    localparam int CTL_DONE_BIT = 13;
    localparam logic [1:0] BURST_FIXED = 2'h0;
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    // Build options
    localparam int AXI_WIDTH_DEFAULT = 16;
    localparam int DOUBLE_BUF_DEFAULT = 0;
    localparam int INFER_RAM_DEFAULT = 1;
    localparam int DMA_BASE_DEFAULT = 0;
    // Buffer index: write a, write b, read a, read b
    localparam int NUM_BUF = 4;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD_CTL = 4'h1,
        ST_RD_ALO = 4'h2,
        ST_RD_AHI = 4'h3,
        ST_ADDR = 4'h4,
        ST_FETCH = 4'h5,
        ST_FETCH_W = 4'h6,
        ST_WDATA = 4'h7,
        ST_BRESP = 4'h8,
        ST_RDATA = 4'h9,
        ST_STORE = 4'hA,
        ST_DONE = 4'hB
    } dma_state_t;
endpackage
`default_nettype wire

// File: core/dma_word_ram.sv
`default_nettype none
module dma_word_ram
    import dma_axi_pkg::*;
(
    input wire logic clk,
    input wire logic a_we,
    input wire logic [MEM_AW-1:0] a_addr,
    input wire logic [MEM_DW-1:0] a_wdata,
    output logic [MEM_DW-1:0] a_rdata,
    input wire logic b_we,
    input wire logic [MEM_AW-1:0] b_addr,
    input wire logic [MEM_DW-1:0] b_wdata,
    output logic [MEM_DW-1:0] b_rdata
);
    logic [MEM_DW-1:0] mem [0:MEM_DEPTH-1];

    // Both ports in one process; engine write placed last so it wins
    // a same-cycle clash, keeping the done flag from being lost
    always_ff @(posedge clk) begin
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
        if (b_we) begin
            mem[b_addr] <= b_wdata;
        end
        a_rdata <= mem[a_addr];
        b_rdata <= mem[b_addr];
    end
endmodule
`default_nettype wire

// File: dv/axi_slave_model.sv
`default_nettype none
module axi_slave_model
    import dma_axi_pkg::*;
#(
    parameter int W = 16
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic [1:0] bresp_cfg,
    input wire logic [1:0] rresp_cfg,
    input wire logic [31:0] m_axi_awaddr,
    input wire logic [7:0] m_axi_awlen,
    input wire logic [1:0] m_axi_awburst,
    input wire logic m_axi_awvalid,
    output logic m_axi_awready,
    input wire logic [W-1:0] m_axi_wdata,
    input wire logic m_axi_wlast,
    input wire logic m_axi_wvalid,
    output logic m_axi_wready,
    output logic [1:0] m_axi_bresp,
    output logic m_axi_bvalid,
    input wire logic m_axi_bready,
    input wire logic [31:0] m_axi_araddr,
    input wire logic [7:0] m_axi_arlen,
    input wire logic [1:0] m_axi_arburst,
    input wire logic m_axi_arvalid,
    output logic m_axi_arready,
    output logic [W-1:0] m_axi_rdata,
    output logic [1:0] m_axi_rresp,
    output logic m_axi_rlast,
    output logic m_axi_rvalid,
    input wire logic m_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] tick_q;
    logic [31:0] aw_addr_q, ar_addr_q;
    logic [7:0] aw_len_q, ar_len_q, rcnt_q;
    logic [1:0] aw_burst_q, ar_burst_q;
    logic [W-1:0] wbeat_q [0:255];
    logic [8:0] wcnt_q;
    logic bvalid_q, rbusy_q, go;
    // Slow mode accepts only every other cycle
    assign go = !slow || tick_q[0];
    assign m_axi_awready = go;
    assign m_axi_wready = go;
    assign m_axi_arready = go && !rbusy_q;
    assign m_axi_bvalid = bvalid_q;
    assign m_axi_rvalid = rbusy_q;
    // Idle lines carry junk, so a stale value is never mistaken for data
    assign m_axi_bresp = bvalid_q ? bresp_cfg : ~bresp_cfg;
    assign m_axi_rdata = rbusy_q ? W'(16'h5000 + rcnt_q) : W'(tick_q);
    assign m_axi_rresp = rbusy_q ? rresp_cfg : tick_q[2:1];
    assign m_axi_rlast = rbusy_q ? (rcnt_q == ar_len_q) : tick_q[0];
    // Write address, beats and response
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_q <= 16'h0000;
            bvalid_q <= 1'b0;
            wcnt_q <= 9'h000;
        end else begin
            tick_q <= tick_q + 16'h0001;
            if (m_axi_awvalid && go) begin
                aw_addr_q <= m_axi_awaddr;
                aw_len_q <= m_axi_awlen;
                aw_burst_q <= m_axi_awburst;
                wcnt_q <= 9'h000;
            end
            if (m_axi_wvalid && go) begin
                wbeat_q[wcnt_q[7:0]] <= m_axi_wdata;
                wcnt_q <= wcnt_q + 9'h001;
                bvalid_q <= m_axi_wlast;
            end
            if (bvalid_q && m_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    // Read address and beat sequencing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rbusy_q <= 1'b0;
        end else if (m_axi_arvalid && m_axi_arready) begin
            ar_addr_q <= m_axi_araddr;
            ar_len_q <= m_axi_arlen;
            ar_burst_q <= m_axi_arburst;
            rcnt_q <= 8'h00;
            rbusy_q <= 1'b1;
        end else if (rbusy_q && m_axi_rready) begin
            rcnt_q <= rcnt_q + 8'h01;
            rbusy_q <= (rcnt_q != ar_len_q);
        end
    end
endmodule
`default_nettype wire

// File: dv/dma_checker.sv
`default_nettype none
module dma_checker
    import dma_axi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cpu_mem_sel,
    input wire logic cpu_mem_we,
    input wire logic [MEM_AW-1:0] cpu_mem_addr,
    input wire logic [MEM_DW-1:0] cpu_mem_wdata,
    input wire logic [NUM_BUF-1:0] irq_vector,
    input wire logic [31:0] m_axi_awaddr,
    input wire logic [7:0] m_axi_awlen,
    input wire logic m_axi_awvalid,
    input wire logic m_axi_awready,
    input wire logic m_axi_wlast,
    input wire logic m_axi_wvalid,
    input wire logic m_axi_wready,
    input wire logic [31:0] m_axi_araddr,
    input wire logic m_axi_arvalid,
    input wire logic m_axi_arready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] len_q, beat_q;
    // Beats of the write burst in flight
    always_ff @(posedge clk) begin
        if (m_axi_awvalid && m_axi_awready) begin
            len_q <= m_axi_awlen;
            beat_q <= 8'h00;
        end else if (m_axi_wvalid && m_axi_wready) begin
            beat_q <= beat_q + 8'h01;
        end
    end
    aw_hold_a: assert property (m_axi_awvalid && !m_axi_awready |=>
        m_axi_awvalid && $stable(m_axi_awaddr) && $stable(m_axi_awlen))
        else $error("write address dropped before ready");
    w_hold_a: assert property (m_axi_wvalid && !m_axi_wready |=>
        m_axi_wvalid && $stable(m_axi_wlast))
        else $error("write beat dropped before ready");
    ar_hold_a: assert property (m_axi_arvalid && !m_axi_arready |=>
        m_axi_arvalid && $stable(m_axi_araddr))
        else $error("read address dropped before ready");
    aw_drop_a: assert property (m_axi_awvalid && m_axi_awready |=>
        !m_axi_awvalid)
        else $error("write address repeated");
    ar_drop_a: assert property (m_axi_arvalid && m_axi_arready |=>
        !m_axi_arvalid)
        else $error("read address repeated");
    one_dir_a: assert property (!(m_axi_arvalid &&
        (m_axi_awvalid || m_axi_wvalid)))
        else $error("read and write in flight together");
    wlast_pos_a: assert property (m_axi_wvalid |->
        m_axi_wlast == (beat_q == len_q))
        else $error("last marker on wrong beat");
    irq_rst_a: assert property ($rose(rst_n) |->
        irq_vector == 4'h0)
        else $error("interrupt set out of reset");
    irq_clr_a: assert property (irq_vector[0] && cpu_mem_sel &&
        cpu_mem_we && cpu_mem_addr == OFF_WCTRL_A &&
        !cpu_mem_wdata[CTL_DONE_BIT] |-> ##[1:2] !irq_vector[0])
        else $error("interrupt kept after done cleared");
endmodule
bind axi_master_dma dma_checker u_chk (.*);
`default_nettype wire

// File: dv/testbench.sv
`default_nettype none
module testbench
    import dma_axi_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
    logic cpu_mem_sel = 1'b0, cpu_mem_we = 1'b0;
    logic [MEM_AW-1:0] cpu_mem_addr = '0;
    logic [MEM_DW-1:0] cpu_mem_wdata = '0, cpu_mem_rdata;
    logic [NUM_BUF-1:0] irq_vector;
    logic [1:0] bresp_cfg = 2'h0, rresp_cfg = 2'h0;
    logic [31:0] m_axi_awaddr, m_axi_araddr;
    logic [7:0] m_axi_awlen, m_axi_arlen;
    logic [1:0] m_axi_awburst, m_axi_arburst, m_axi_bresp, m_axi_rresp;
    logic [15:0] m_axi_wdata, m_axi_rdata;
    logic m_axi_awvalid, m_axi_awready, m_axi_wlast, m_axi_wvalid;
    logic m_axi_wready, m_axi_bvalid, m_axi_bready, m_axi_arvalid;
    logic m_axi_arready, m_axi_rlast, m_axi_rvalid, m_axi_rready;
    int n_errors = 0, samples_checked = 0;
    // Buffer index order: write a, write b, read a, read b
    logic [9:0] bo_tab [4] = '{OFF_WBUF_A, OFF_WBUF_B, OFF_RBUF_A, OFF_RBUF_B};
    logic [9:0] ao_tab [4] = '{OFF_WADDR_LO_A, OFF_WADDR_LO_B,
        OFF_RADDR_LO_A, OFF_RADDR_LO_B};
    axi_master_dma #(.DOUBLE_BUFFERING(1)) dut (.*);
    axi_slave_model u_slave (.*);
    initial forever #50 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic mem_wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        cpu_mem_sel = 1'b1;
        cpu_mem_we = 1'b1;
        cpu_mem_addr = a;
        cpu_mem_wdata = d;
        @(posedge clk);
        #1;
        cpu_mem_sel = 1'b0;
        cpu_mem_we = 1'b0;
    endtask
    // Read data is registered, so it is taken one edge after the address
    task automatic mem_rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        cpu_mem_sel = 1'b1;
        cpu_mem_addr = a;
        @(posedge clk);
        #1;
        d = cpu_mem_rdata;
        cpu_mem_sel = 1'b0;
    endtask
    task automatic run_xfer(input logic [1:0] idx, input logic [7:0] len,
        input logic [1:0] bt, input logic [1:0] resp);
        logic [31:0] adr;
        logic [15:0] d;
        int n;
        adr = 32'h4A5C_1230 + {idx, 24'h0};
        bresp_cfg = resp;
        rresp_cfg = resp;
        if (!idx[1])
            for (n = 0; n <= len; n++)
                mem_wr(bo_tab[idx] + 10'(n), 16'hA000 + 16'(n));
        mem_wr(ao_tab[idx], adr[15:0]);
        mem_wr(ao_tab[idx] + 10'h1, adr[31:16]);
        check("early", 32'(m_axi_awvalid|m_axi_arvalid), 32'h0);
        mem_wr(10'(idx), {5'h00, 1'b1, bt, len});
        n = 0;
        while (irq_vector[idx] !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("irq", 32'(irq_vector), 32'(1 << idx));
        if (idx[1]) begin
            check("araddr", u_slave.ar_addr_q, adr);
            check("arlen", 32'(u_slave.ar_len_q), 32'(len));
            check("arburst", 32'(u_slave.ar_burst_q), 32'(bt));
            for (n = 0; n <= len; n++) begin
                mem_rd(bo_tab[idx] + 10'(n), d);
                check("rbuf", 32'(d), 32'h5000 + n);
            end
        end else begin
            check("awaddr", u_slave.aw_addr_q, adr);
            check("awlen", 32'(u_slave.aw_len_q), 32'(len));
            check("awburst", 32'(u_slave.aw_burst_q), 32'(bt));
            check("beats", 32'(u_slave.wcnt_q), len + 32'h1);
            for (n = 0; n <= len; n++) begin
                d = u_slave.wbeat_q[n];
                check("wbeat", 32'(d), 32'hA000 + n);
            end
        end
        mem_rd(10'(idx), d);
        check("ctrl", 32'(d), {18'h0, 1'b1, resp, 1'b0, bt, len});
        mem_wr(10'(idx), 16'h0000);
        @(posedge clk);
        #1;
        check("irq clear", 32'(irq_vector), 32'h0);
    endtask
    task automatic t_write_a();
        slow = 1'b0;
        run_xfer(2'h0, 8'h03, BURST_INCR, 2'h0);
        $display("t_write_a finished");
    endtask
    task automatic t_write_b();
        slow = 1'b1;
        run_xfer(2'h1, 8'hFB, BURST_FIXED, 2'h2);
        $display("t_write_b finished");
    endtask
    task automatic t_read_a();
        slow = 1'b1;
        run_xfer(2'h2, 8'h05, BURST_WRAP, 2'h1);
        $display("t_read_a finished");
    endtask
    task automatic t_read_b();
        slow = 1'b0;
        run_xfer(2'h3, 8'h00, BURST_INCR, 2'h3);
        $display("t_read_b finished");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("irq reset", 32'(irq_vector), 32'h0);
        t_write_a();
        t_write_b();
        t_read_a();
        t_read_b();
        complete_run();
    end
    // Whole run needs under two thousand cycles
    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
